//--- hw/pin_edge_stage.v
// Purpose: two-flop synchronisers and edge detection for the asynchronous pins
// Assumes: pins are outside the clock domain; one rising clock edge per sample
// Notes:   edge pulses and levels come straight from flip-flops
`timescale 1ns/10ps
module pin_edge_stage #(
  parameter       WIDTH = 7,
  parameter [6:0] IDLE  = 7'h00
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  input  wire [WIDTH-1:0] pins,
  output reg  [WIDTH-1:0] level,
  output reg  [WIDTH-1:0] rise,
  output reg  [WIDTH-1:0] fall
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] prev;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      // meta is read only by level, so no gate sees a metastable value
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta[i]  <= IDLE[i];
          level[i] <= IDLE[i];
          prev[i]  <= IDLE[i];
          rise[i]  <= 1'b0;
          fall[i]  <= 1'b0;
        end else if (ce) begin
          meta[i]  <= pins[i];
          level[i] <= meta[i];
          prev[i]  <= level[i];
          rise[i]  <= level[i] & ~prev[i];
          fall[i]  <= ~level[i] & prev[i];
        end
      end
    end
  endgenerate

endmodule // pin_edge_stage

//--- hw/pmu_event_regs.vh
// Purpose: register map, field positions and timing constants of the event block
// Assumes: 8-bit register port, 10 MHz reference clock
// Notes:   included by the event block only; it passes pin count and idle levels to its pin edge stage
`ifndef PMU_EVENT_REGS_VH
`define PMU_EVENT_REGS_VH

// register offsets
`define ADDR_EVENT_STATUS_PRIMARY  8'h50
`define ADDR_EVENT_MASK_PRIMARY    8'h51
`define ADDR_GPIO_EDGE_STATUS_LOW  8'h52
`define ADDR_GPIO_EDGE_MASK_LOW    8'h53
`define ADDR_PENDING_PRIMARY       8'h5D
`define ADDR_PENDING_GPIO          8'h5E
`define ADDR_PIN_LEVEL             8'h5F

// primary status and mask layout
`define BIT_CLOCK_TICK    7
`define BIT_CLOCK_ALARM   6
`define BIT_OVERTEMP      5
`define BIT_HOLD_RISE     4
`define BIT_BUTTON_LONG   3
`define BIT_BUTTON_PRESS  2
`define BIT_RESERVED      1
`define BIT_HOLD_FALL     0

// gpio edge layout: rise of pin n at 2n, fall at 2n+1
`define GPIO_COUNT        4

// pin bundle positions inside the edge stage
`define PIN_HOLD          4
`define PIN_OVERTEMP      5
`define PIN_BUTTON        6
`define PIN_COUNT         7
// idle levels caught by the synchroniser at reset; button is active low
`define PIN_IDLE          7'h40

// reset values
`define STATUS_RESET      8'h00
`define MASK_RESET        8'hFF
`define READ_ZERO         8'h00

// timing
`define CLK_FREQ_KHZ      10000
`define LONG_PRESS_MS     1000

`endif

//--- hw/pmu_event_status_mask.v
// Purpose: sticky event status, per-event masks and one level interrupt line
// Assumes: pins pass two flops; tick and alarm are one-cycle pulses on REF_CLK
// Notes:   status clears only on RESET_N; masks also on GENERAL_RESET
//
// What this block does
// - a detected event sets its status bit, which stays set until cleared
// - writing one clears a status bit; writing zero leaves it alone
// - a set mask bit keeps the event off the interrupt line, status still sets
// - a clear mask bit lets the event set status and raise the line
// - hold input falling edge reports in primary status bit 0, mask bit 0
// - hold input rising edge reports in primary status bit 4, mask bit 4
// - power button long press reports in primary status bit 3, mask bit 3
// - gpio n falling edge reports in second status bit 2n+1
// - gpio n rising edge reports in second status bit 2n
// - primary mask resets to all ones on general reset; bit 1 stays masking
// - status registers clear to zero only on full reset
// - gpio edge mask at 0x53 matches second status layout, resets to ones
`timescale 1ns/10ps
`include "pmu_event_regs.vh"
module pmu_event_status_mask #(
  parameter [31:0] LONG_PRESS_CYCLES = `LONG_PRESS_MS * `CLK_FREQ_KHZ
) (
  input  wire       REF_CLK,
  input  wire       RESET_N,
  input  wire       GENERAL_RESET,
  input  wire       CLK_EN,
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  input  wire       CLOCK_TICK,
  input  wire       CLOCK_ALARM,
  input  wire       OVERTEMP_INPUT,
  input  wire       HOLD_POWER_INPUT,
  input  wire       POWER_BUTTON_INPUT_N,
  input  wire [3:0] GPIO_INPUT,
  output reg        IRQ_OUT_LINE
);

  localparam [31:0] LONG_LAST = LONG_PRESS_CYCLES - 32'h0000_0001;

  wire [`PIN_COUNT-1:0] pin_bundle;
  wire [`PIN_COUNT-1:0] pin_level;
  wire [`PIN_COUNT-1:0] pin_rise;
  wire [`PIN_COUNT-1:0] pin_fall;

  reg  [7:0]  event_status_primary;
  reg  [7:0]  event_mask_primary;
  reg  [7:0]  gpio_edge_status_low;
  reg  [7:0]  gpio_edge_mask_low;
  reg  [31:0] press_count;
  reg         long_done;

  reg  [7:0]  next_event_status_primary;
  reg  [7:0]  next_gpio_edge_status_low;
  reg  [7:0]  primary_set;
  reg  [7:0]  gpio_set;
  reg  [7:0]  next_rdata;

  wire        clock_tick_flag;
  wire        clock_alarm_flag;
  wire        overtemp_flag;
  wire        hold_rise_flag;
  wire        hold_fall_flag;
  wire        button_press_flag;
  wire        button_long_flag;
  wire        pin0_rise_flag;
  wire        pin3_fall_flag;
  wire        button_held;
  wire [7:0]  pending_primary;
  wire [7:0]  pending_gpio;
  wire        next_irq;

  wire        wr_status_primary;
  wire        wr_mask_primary;
  wire        wr_status_gpio;
  wire        wr_mask_gpio;

  assign pin_bundle = {POWER_BUTTON_INPUT_N, OVERTEMP_INPUT, HOLD_POWER_INPUT, GPIO_INPUT};

  pin_edge_stage #(
    .WIDTH (`PIN_COUNT),
    .IDLE  (`PIN_IDLE)
  ) u_pins (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .ce    (CLK_EN),
    .pins  (pin_bundle),
    .level (pin_level),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // event sources
  assign clock_tick_flag   = CLOCK_TICK;
  assign clock_alarm_flag  = CLOCK_ALARM;
  assign overtemp_flag     = pin_rise[`PIN_OVERTEMP];
  assign hold_rise_flag    = pin_rise[`PIN_HOLD];
  assign hold_fall_flag    = pin_fall[`PIN_HOLD];
  // button is active low: a press is the falling edge
  assign button_press_flag = pin_fall[`PIN_BUTTON];
  assign button_held       = ~pin_level[`PIN_BUTTON];
  assign button_long_flag  = button_held & ~long_done & (press_count == LONG_LAST);
  assign pin0_rise_flag    = pin_rise[0];
  assign pin3_fall_flag    = pin_fall[3];

  // long press timer; fires once per hold, rearms on release
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      press_count <= 32'h0000_0000;
      long_done   <= 1'b0;
    end else if (CLK_EN) begin
      if (!button_held) begin
        press_count <= 32'h0000_0000;
        long_done   <= 1'b0;
      end else if (button_long_flag) begin
        long_done   <= 1'b1;
      end else if (!long_done) begin
        press_count <= press_count + 32'h0000_0001;
      end
    end
  end

  // register decode
  assign wr_status_primary = WR & (ADDR == `ADDR_EVENT_STATUS_PRIMARY);
  assign wr_mask_primary   = WR & (ADDR == `ADDR_EVENT_MASK_PRIMARY);
  assign wr_status_gpio    = WR & (ADDR == `ADDR_GPIO_EDGE_STATUS_LOW);
  assign wr_mask_gpio      = WR & (ADDR == `ADDR_GPIO_EDGE_MASK_LOW);

  // gather set terms per bit
  integer n;
  always @* begin
    primary_set = `STATUS_RESET;
    primary_set[`BIT_CLOCK_TICK]   = clock_tick_flag;
    primary_set[`BIT_CLOCK_ALARM]  = clock_alarm_flag;
    primary_set[`BIT_OVERTEMP]     = overtemp_flag;
    primary_set[`BIT_HOLD_RISE]    = hold_rise_flag;
    primary_set[`BIT_BUTTON_LONG]  = button_long_flag;
    primary_set[`BIT_BUTTON_PRESS] = button_press_flag;
    primary_set[`BIT_HOLD_FALL]    = hold_fall_flag;
    gpio_set = `STATUS_RESET;
    for (n = 0; n < `GPIO_COUNT; n = n + 1) begin
      gpio_set[2*n]   = pin_rise[n];
      gpio_set[2*n+1] = pin_fall[n];
    end
    gpio_set[0] = pin0_rise_flag;
    gpio_set[7] = pin3_fall_flag;
  end

  // sticky status; a set in the clear cycle wins
  always @* begin
    next_event_status_primary = event_status_primary;
    next_gpio_edge_status_low = gpio_edge_status_low;
    if (wr_status_primary) begin
      next_event_status_primary = event_status_primary & ~WDATA;
    end
    if (wr_status_gpio) begin
      next_gpio_edge_status_low = gpio_edge_status_low & ~WDATA;
    end
    next_event_status_primary = next_event_status_primary | primary_set;
    next_gpio_edge_status_low = next_gpio_edge_status_low | gpio_set;
    next_event_status_primary[`BIT_RESERVED] = 1'b0;
  end

  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      event_status_primary <= `STATUS_RESET;
      gpio_edge_status_low <= `STATUS_RESET;
    end else if (CLK_EN) begin
      // general reset leaves status untouched
      event_status_primary <= next_event_status_primary;
      gpio_edge_status_low <= next_gpio_edge_status_low;
    end
  end

  // masks: one means masked
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      event_mask_primary <= `MASK_RESET;
      gpio_edge_mask_low <= `MASK_RESET;
    end else if (CLK_EN) begin
      if (GENERAL_RESET) begin
        event_mask_primary <= `MASK_RESET;
        gpio_edge_mask_low <= `MASK_RESET;
      end else begin
        if (wr_mask_primary) begin
          event_mask_primary <= WDATA | (`STATUS_RESET | (8'h01 << `BIT_RESERVED));
        end
        if (wr_mask_gpio) begin
          gpio_edge_mask_low <= WDATA;
        end
      end
    end
  end

  // interrupt line; registered, so it trails status by one cycle
  assign pending_primary = event_status_primary & ~event_mask_primary;
  assign pending_gpio    = gpio_edge_status_low & ~gpio_edge_mask_low;
  assign next_irq        = (|pending_primary) | (|pending_gpio);

  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_OUT_LINE <= 1'b0;
    end else if (CLK_EN) begin
      IRQ_OUT_LINE <= next_irq;
    end
  end

  // read mux; unmapped offsets read zero, reads have no side effect
  always @* begin
    next_rdata = `READ_ZERO;
    case (ADDR)
      `ADDR_EVENT_STATUS_PRIMARY: next_rdata = event_status_primary;
      `ADDR_EVENT_MASK_PRIMARY:   next_rdata = event_mask_primary;
      `ADDR_GPIO_EDGE_STATUS_LOW: next_rdata = gpio_edge_status_low;
      `ADDR_GPIO_EDGE_MASK_LOW:   next_rdata = gpio_edge_mask_low;
      `ADDR_PENDING_PRIMARY:      next_rdata = pending_primary;
      `ADDR_PENDING_GPIO:         next_rdata = pending_gpio;
      `ADDR_PIN_LEVEL:            next_rdata = {1'b0, pin_level};
      default:                    next_rdata = `READ_ZERO;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= `READ_ZERO;
    end else if (CLK_EN) begin
      if (RD) begin
        RDATA <= next_rdata;
      end else begin
        RDATA <= `READ_ZERO;
      end
    end
  end

endmodule // pmu_event_status_mask

//--- verif/irq_host_model.sv
// Purpose: host side of the interrupt line
// Assumes: level line sampled on the block clock
// Notes:   counts raises only, a held level is one request
`timescale 1ns/10ps
module irq_host_model (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       irq,
  output reg  [7:0] seen
);
  reg last;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last <= 1'b0;
      seen <= 8'h00;
    end else begin
      last <= irq;
      if (irq && !last) begin
        seen <= seen + 8'h01;
      end
    end
  end
endmodule // irq_host_model

//--- verif/pmu_event_props.sv
// Purpose: assertions on the event block ports
// Assumes: bound to the top module, one clock domain
// Notes:   shadow masks follow writes, since the real ones are hidden
`timescale 1ns/10ps
module pmu_event_props (
  input wire       REF_CLK,
  input wire       RESET_N,
  input wire       GENERAL_RESET,
  input wire       CLK_EN,
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire       WR,
  input wire       RD,
  input wire [7:0] RDATA,
  input wire       CLOCK_TICK,
  input wire       CLOCK_ALARM,
  input wire       IRQ_OUT_LINE
);
  reg [7:0] msk;
  reg [7:0] gmsk;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      msk  <= 8'hFF;
      gmsk <= 8'hFF;
    end else if (CLK_EN && GENERAL_RESET) begin
      msk  <= 8'hFF;
      gmsk <= 8'hFF;
    end else if (CLK_EN && WR && ADDR == 8'h51) begin
      msk <= WDATA | 8'h02;
    end else if (CLK_EN && WR && ADDR == 8'h53) begin
      gmsk <= WDATA;
    end
  end
  property p_resv; $past(RD && CLK_EN && ADDR == 8'h50) |-> !RDATA[1]; endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_mrd; $past(RD && CLK_EN && ADDR == 8'h51) |-> RDATA == $past(msk); endproperty
  a_mrd: assert property (p_mrd) else $error("mask read wrong");
  property p_grd; $past(RD && CLK_EN && ADDR == 8'h53) |-> RDATA == $past(gmsk); endproperty
  a_grd: assert property (p_grd) else $error("gpio mask read wrong");
  property p_tick;
    CLOCK_TICK && CLK_EN && !WR && !GENERAL_RESET && !msk[7] ##1 CLK_EN |=> IRQ_OUT_LINE;
  endproperty
  a_tick: assert property (p_tick) else $error("tick gave no irq");
  property p_alarm;
    CLOCK_ALARM && CLK_EN && !WR && !GENERAL_RESET && !msk[6] ##1 CLK_EN |=> IRQ_OUT_LINE;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm gave no irq");
  property p_masked;
    $past(CLK_EN) && $past(msk) == 8'hFF && $past(gmsk) == 8'hFF |-> !IRQ_OUT_LINE;
  endproperty
  a_masked: assert property (p_masked) else $error("irq while masked");
  property p_fall; $fell(IRQ_OUT_LINE) |-> $past(WR, 2) || $past(GENERAL_RESET, 2); endproperty
  a_fall: assert property (p_fall) else $error("irq fell uncleared");
  property p_grst; GENERAL_RESET && CLK_EN ##1 CLK_EN |=> !IRQ_OUT_LINE; endproperty
  a_grst: assert property (p_grst) else $error("irq after general reset");
endmodule // pmu_event_props

bind pmu_event_status_mask pmu_event_props u_pmu_event_props (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .GENERAL_RESET(GENERAL_RESET), .CLK_EN(CLK_EN),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CLOCK_TICK(CLOCK_TICK),
  .CLOCK_ALARM(CLOCK_ALARM), .IRQ_OUT_LINE(IRQ_OUT_LINE)
);

//--- verif/pmu_event_status_mask_test.sv
// Purpose: self-checking bench for the event block
// Assumes: clock enable high except in the freeze scenario, short long-press count
// Notes:   pin waits follow the two-flop latency
`timescale 1ns/10ps
module pmu_event_status_mask_test;
  reg        REF_CLK = 1'b0;
  reg        RESET_N = 1'b0;
  reg        GENERAL_RESET = 1'b0;
  reg        CLK_EN = 1'b1;
  reg  [7:0] ADDR = 8'h00;
  reg  [7:0] WDATA = 8'h00;
  reg        WR = 1'b0;
  reg        RD = 1'b0;
  reg        CLOCK_TICK = 1'b0;
  reg        CLOCK_ALARM = 1'b0;
  reg        OVERTEMP_INPUT = 1'b0;
  reg        HOLD_POWER_INPUT = 1'b0;
  reg        POWER_BUTTON_INPUT_N = 1'b1;
  reg  [3:0] GPIO_INPUT = 4'h0;
  wire [7:0] RDATA;
  wire       IRQ_OUT_LINE;
  wire [7:0] seen;
  integer    n_mismatch = 0;
  integer    check_count = 0;
  integer    n_irq = 0;
  integer    n;
  pmu_event_status_mask #(.LONG_PRESS_CYCLES(32'h0000_0008)) u_pmu_event_status_mask (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .GENERAL_RESET(GENERAL_RESET), .CLK_EN(CLK_EN),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CLOCK_TICK(CLOCK_TICK),
    .CLOCK_ALARM(CLOCK_ALARM), .OVERTEMP_INPUT(OVERTEMP_INPUT),
    .HOLD_POWER_INPUT(HOLD_POWER_INPUT), .POWER_BUTTON_INPUT_N(POWER_BUTTON_INPUT_N),
    .GPIO_INPUT(GPIO_INPUT), .IRQ_OUT_LINE(IRQ_OUT_LINE));
  irq_host_model u_irq_host_model (.clk(REF_CLK), .rst_n(RESET_N), .irq(IRQ_OUT_LINE),
    .seen(seen));
  initial begin
    forever #50 REF_CLK = ~REF_CLK;
  end
  task chk(input [63:0] name, input [7:0] exp, input [7:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge REF_CLK);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge REF_CLK) {WR, ADDR, WDATA} <= {1'b1, a, d};
      @(posedge REF_CLK) WR <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge REF_CLK) {RD, ADDR} <= {1'b1, a};
      @(posedge REF_CLK) RD <= 1'b0;
      #1 chk("rdata", exp, RDATA);
    end
  endtask
  task irq(input exp);
    #1 chk("irq", {7'h00, exp}, {7'h00, IRQ_OUT_LINE});
  endtask
  task s_tick;
    begin
      wr(8'h51, 8'h00);
      rd(8'h51, 8'h02);
      @(posedge REF_CLK) CLOCK_TICK <= 1'b1;
      @(posedge REF_CLK) CLOCK_TICK <= 1'b0;
      cyc(1);
      irq(1'b1);
      rd(8'h50, 8'h80);
      rd(8'h5D, 8'h80);
      wr(8'h50, 8'h00);
      rd(8'h50, 8'h80);
      wr(8'h50, 8'h80);
      cyc(1);
      irq(1'b0);
      wr(8'h51, 8'h40);
      @(posedge REF_CLK) CLOCK_ALARM <= 1'b1;
      @(posedge REF_CLK) CLOCK_ALARM <= 1'b0;
      rd(8'h50, 8'h40);
      irq(1'b0);
      wr(8'h51, 8'h00);
      cyc(1);
      irq(1'b1);
      wr(8'h50, 8'h40);
      // unmasked alarm, so its assertion sees a live antecedent
      @(posedge REF_CLK) CLOCK_ALARM <= 1'b1;
      @(posedge REF_CLK) CLOCK_ALARM <= 1'b0;
      cyc(1);
      irq(1'b1);
      wr(8'h50, 8'h40);
      n_irq = n_irq + 3;
    end
  endtask
  task s_pins;
    begin
      wr(8'h51, 8'hFF);
      @(posedge REF_CLK) HOLD_POWER_INPUT <= 1'b1;
      cyc(6);
      rd(8'h50, 8'h10);
      @(posedge REF_CLK) HOLD_POWER_INPUT <= 1'b0;
      cyc(6);
      rd(8'h50, 8'h11);
      @(posedge REF_CLK) OVERTEMP_INPUT <= 1'b1;
      @(posedge REF_CLK) POWER_BUTTON_INPUT_N <= 1'b0;
      cyc(4);
      rd(8'h50, 8'h35);
      cyc(20);
      rd(8'h50, 8'h3D);
      rd(8'h5F, 8'h20);
      wr(8'h50, 8'hFF);
      rd(8'h50, 8'h00);
      @(posedge REF_CLK) {OVERTEMP_INPUT, POWER_BUTTON_INPUT_N} <= 2'b01;
    end
  endtask
  task s_gpio;
    begin
      for (n = 0; n < 4; n = n + 1) begin
        @(posedge REF_CLK) GPIO_INPUT[n] <= 1'b1;
        cyc(6);
        rd(8'h52, 8'h01 << (2 * n));
        @(posedge REF_CLK) GPIO_INPUT[n] <= 1'b0;
        cyc(6);
        rd(8'h52, 8'h03 << (2 * n));
        wr(8'h52, 8'h03 << (2 * n));
      end
      wr(8'h53, 8'h00);
      @(posedge REF_CLK) GPIO_INPUT[3] <= 1'b1;
      cyc(7);
      irq(1'b1);
      rd(8'h5E, 8'h40);
      n_irq = n_irq + 1;
      @(posedge REF_CLK) GENERAL_RESET <= 1'b1;
      @(posedge REF_CLK) GENERAL_RESET <= 1'b0;
      cyc(1);
      irq(1'b0);
      rd(8'h51, 8'hFF);
      rd(8'h53, 8'hFF);
      rd(8'h52, 8'h40);
    end
  endtask
  // tick and mask write while frozen must both be lost
  task s_hold;
    begin
      @(posedge REF_CLK) CLK_EN <= 1'b0;
      @(posedge REF_CLK) {CLOCK_TICK, WR, ADDR, WDATA} <= {1'b1, 1'b1, 8'h51, 8'h00};
      @(posedge REF_CLK) {CLOCK_TICK, WR} <= 2'b00;
      @(posedge REF_CLK) CLK_EN <= 1'b1;
      rd(8'h50, 8'h00);
      rd(8'h51, 8'hFF);
    end
  endtask
  // pin back to idle first, else the release shows a false edge
  task s_full;
    begin
      @(posedge REF_CLK) GPIO_INPUT[3] <= 1'b0;
      @(posedge REF_CLK) RESET_N <= 1'b0;
      cyc(2);
      @(posedge REF_CLK) RESET_N <= 1'b1;
      rd(8'h52, 8'h00);
      rd(8'h51, 8'hFF);
      rd(8'h53, 8'hFF);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #6000000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    rd(8'h50, 8'h00);
    rd(8'h53, 8'hFF);
    rd(8'h60, 8'h00);
    s_tick;
    s_pins;
    s_gpio;
    chk("host", n_irq[7:0], seen);
    s_hold;
    s_full;
    complete_run;
  end
endmodule // pmu_event_status_mask_test
